/* File: design/dac_control_status_regs.sv */
/*
 * Control and status register bank for the converter: full-scale current,
 * sleep, quad-switch mode, clock phase status and receiver controller
 * configuration with lock flags.
 * Assumes a serial configuration front end presenting one byte access
 * per strobe, synchronous to i_clk.
 */
`timescale 1ns/100ps
module dac_control_status_regs
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // Register access from the serial front end
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Receiver controller status
    input wire logic i_rx_locked,
    input wire logic i_early_phase0_compare,
    input wire logic i_late_phase0_compare,
    // Controls out
    output dac_regs_pkg::dac_cfg_t o_dac_cfg,
    output dac_regs_pkg::rx_ctrl_t o_rx_ctrl
);

    dac_regs_pkg::bank_state_t state_r;
    dac_regs_pkg::bank_state_t state_nxt;
    logic [1:0] lock_flags;
    logic lost_event;

    // ========================================================
    // Lock flag capture
    lock_flag_capture u_capture
    (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_enable_cur(state_r.irq_enable),
        .i_enable_nxt(state_nxt.irq_enable),
        .i_flag_clear(state_r.flag_clear_pulse), // RULE11
        .i_locked(i_rx_locked),
        .o_flags(lock_flags),
        .o_lost_event(lost_event)
    );

    // ========================================================
    // Register writes and reads
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.flag_clear_pulse = 1'b0;
        // Restart only when the controller runs and auto-relock is on
        state_nxt.restart_pulse = lost_event & state_r.auto_relock &
            state_r.ctrl_on; // RULE12
        if (i_wr)
        begin
            case (i_addr)
                dac_regs_pkg::OFS_IRQ_ENABLE:
                begin
                    // Host clears then re-arms after service
                    state_nxt.irq_enable = i_wdata[1:0]; // RULE3 RULE4
                end
                dac_regs_pkg::OFS_FSC_LOW:
                begin
                    state_nxt.fsc_low = i_wdata; // RULE5
                end
                dac_regs_pkg::OFS_FSC_HIGH_SLEEP:
                begin
                    state_nxt.fsc_high = i_wdata[1:0]; // RULE5
                    state_nxt.sleep = i_wdata[dac_regs_pkg::BIT_SLEEP]; // RULE7
                end
                dac_regs_pkg::OFS_SWITCH_MODE:
                begin
                    state_nxt.switch_mode_field = i_wdata[1:0]; // RULE8
                end
                dac_regs_pkg::OFS_RX_CONFIG:
                begin
                    state_nxt.auto_relock =
                        i_wdata[dac_regs_pkg::BIT_AUTO_RELOCK]; // RULE12
                    state_nxt.ctrl_on =
                        i_wdata[dac_regs_pkg::BIT_CTRL_ON]; // RULE13
                    // Pulse on a 0 written after a 1
                    state_nxt.flag_clear_armed =
                        i_wdata[dac_regs_pkg::BIT_FLAG_CLEAR];
                    state_nxt.flag_clear_pulse = state_r.flag_clear_armed &
                        ~i_wdata[dac_regs_pkg::BIT_FLAG_CLEAR]; // RULE11
                end
                default:
                begin
                    state_nxt.irq_enable = state_nxt.irq_enable;
                end
            endcase
        end
        if (i_rd)
        begin
            state_nxt.rdata = 8'h00;
            case (i_addr)
                dac_regs_pkg::OFS_IRQ_ENABLE:
                begin
                    state_nxt.rdata[1:0] = state_r.irq_enable;
                end
                dac_regs_pkg::OFS_LOCK_STATUS:
                begin
                    state_nxt.rdata[dac_regs_pkg::BIT_LOST] =
                        lock_flags[dac_regs_pkg::BIT_LOST]; // RULE1
                    state_nxt.rdata[dac_regs_pkg::BIT_LOCKED] =
                        lock_flags[dac_regs_pkg::BIT_LOCKED]; // RULE2
                end
                dac_regs_pkg::OFS_FSC_LOW:
                begin
                    state_nxt.rdata = state_r.fsc_low;
                end
                dac_regs_pkg::OFS_FSC_HIGH_SLEEP:
                begin
                    state_nxt.rdata[1:0] = state_r.fsc_high;
                    state_nxt.rdata[dac_regs_pkg::BIT_SLEEP] = state_r.sleep;
                end
                dac_regs_pkg::OFS_SWITCH_MODE:
                begin
                    state_nxt.rdata[1:0] = state_r.switch_mode_field;
                end
                dac_regs_pkg::OFS_PHASE_STATUS:
                begin
                    state_nxt.rdata[dac_regs_pkg::BIT_EARLY_PH0] =
                        i_early_phase0_compare; // RULE9
                    state_nxt.rdata[dac_regs_pkg::BIT_LATE_PH0] =
                        i_late_phase0_compare; // RULE10
                end
                dac_regs_pkg::OFS_RX_CONFIG:
                begin
                    // Flag reset bit is write-only and reads as zero
                    state_nxt.rdata[dac_regs_pkg::BIT_AUTO_RELOCK] =
                        state_r.auto_relock;
                    state_nxt.rdata[dac_regs_pkg::BIT_CTRL_ON] =
                        state_r.ctrl_on;
                end
                default:
                begin
                    state_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_r <= '0;
            state_r.irq_enable <= dac_regs_pkg::RST_IRQ_ENABLE;
            state_r.fsc_low <= dac_regs_pkg::RST_FSC_LOW; // RULE6
            state_r.fsc_high <= dac_regs_pkg::RST_FSC_HIGH; // RULE6
            state_r.sleep <= dac_regs_pkg::RST_SLEEP; // RULE14
            state_r.switch_mode_field <= dac_regs_pkg::RST_SWITCH_MODE; // RULE8
            state_r.auto_relock <= dac_regs_pkg::RST_AUTO_RELOCK; // RULE12
            state_r.ctrl_on <= dac_regs_pkg::RST_CTRL_ON; // RULE13
        end
        else if (i_ce)
        begin
            state_r <= state_nxt;
        end
    end

    // ========================================================
    // Outputs, all from flip-flops
    assign o_rdata = state_r.rdata;
    assign o_dac_cfg.full_scale_code = {state_r.fsc_high, state_r.fsc_low};
    assign o_dac_cfg.sleep = state_r.sleep;
    assign o_dac_cfg.switch_mode_field = state_r.switch_mode_field;
    assign o_rx_ctrl.receiver_controller_on = state_r.ctrl_on;
    assign o_rx_ctrl.receiver_auto_relock = state_r.auto_relock;
    assign o_rx_ctrl.receiver_flag_clear = state_r.flag_clear_pulse;
    assign o_rx_ctrl.restart_search = state_r.restart_pulse;

endmodule : dac_control_status_regs

/* File: design/dac_regs_pkg.sv */
/*
 * Constants and carrier types for the converter control and status
 * register bank: offsets, bit positions, reset values and packed structs.
 * Assumes a serial configuration front end that delivers byte-wide
 * register reads and writes synchronous to the bank clock.
 */
// Overview of operation
// RULE1 - Lost-lock status is read-only bit 1
// RULE2 - Locked status is read-only bit 0
// RULE3 - Enable 0 clears status; 1 re-arms capture
// RULE4 - Host clears then re-arms enables after service
// RULE5 - Ten-bit full-scale code split over two registers
// RULE6 - Full-scale code resets to 0x200 nominal
// RULE7 - Upper register bit 7 puts output asleep
// RULE8 - Two-bit switch mode, baseband reset, 2 mix
// RULE9 - Status bit 2 shows early phase compare
// RULE10 - Status bit 0 shows late phase compare
// RULE11 - Flag reset on write 1 then 0
// RULE12 - Auto-relock flags loss and restarts search
// RULE13 - Bit 0 enables receiver controller, reset off
// RULE14 - Sleep bit resets to output enabled
package dac_regs_pkg;

    // ========================================================
    // Register offsets
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h03;
    localparam logic [7:0] OFS_LOCK_STATUS = 8'h04;
    localparam logic [7:0] OFS_FSC_LOW = 8'h06;
    localparam logic [7:0] OFS_FSC_HIGH_SLEEP = 8'h07;
    localparam logic [7:0] OFS_SWITCH_MODE = 8'h08;
    localparam logic [7:0] OFS_PHASE_STATUS = 8'h0c;
    localparam logic [7:0] OFS_RX_CONFIG = 8'h10;

    // ========================================================
    // Bit positions
    localparam int BIT_LOCKED = 0;
    localparam int BIT_LOST = 1;
    localparam int BIT_SLEEP = 7;
    localparam int BIT_EARLY_PH0 = 2;
    localparam int BIT_LATE_PH0 = 0;
    localparam int BIT_FLAG_CLEAR = 2;
    localparam int BIT_AUTO_RELOCK = 1;
    localparam int BIT_CTRL_ON = 0;

    // ========================================================
    // Reset values
    localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;
    localparam logic [7:0] RST_FSC_LOW = 8'h00;
    localparam logic [1:0] RST_FSC_HIGH = 2'h2;
    localparam logic RST_SLEEP = 1'b0;
    localparam logic [1:0] RST_SWITCH_MODE = 2'h0;
    localparam logic RST_AUTO_RELOCK = 1'b1;
    localparam logic RST_CTRL_ON = 1'b0;

    // ========================================================
    // Switch modes
    localparam logic [1:0] MODE_BASEBAND = 2'h0;
    localparam logic [1:0] MODE_MIX = 2'h2;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic [9:0] full_scale_code;
        logic sleep;
        logic [1:0] switch_mode_field;
    } dac_cfg_t;

    typedef struct packed {
        logic receiver_controller_on;
        logic receiver_auto_relock;
        logic receiver_flag_clear;
        logic restart_search;
    } rx_ctrl_t;

    typedef struct packed {
        logic locked_d;
        logic [1:0] flags;
    } capture_state_t;

    typedef struct packed {
        logic [1:0] irq_enable;
        logic [7:0] fsc_low;
        logic [1:0] fsc_high;
        logic sleep;
        logic [1:0] switch_mode_field;
        logic auto_relock;
        logic ctrl_on;
        logic flag_clear_armed;
        logic flag_clear_pulse;
        logic restart_pulse;
        logic [7:0] rdata;
    } bank_state_t;

endpackage : dac_regs_pkg

/* File: design/lock_flag_capture.sv */
/*
 * Sticky capture of the receiver locked and lost-lock flags.
 * Assumes the lock level is synchronous to i_clk.
 */
`timescale 1ns/100ps
module lock_flag_capture
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // Control
    input wire logic [1:0] i_enable_cur,
    input wire logic [1:0] i_enable_nxt,
    input wire logic i_flag_clear,
    input wire logic i_locked,
    // Status
    output logic [1:0] o_flags,
    output logic o_lost_event
);

    dac_regs_pkg::capture_state_t state_r;
    dac_regs_pkg::capture_state_t state_nxt;
    logic [1:0] events;

    assign events[dac_regs_pkg::BIT_LOCKED] = i_locked & ~state_r.locked_d;
    assign events[dac_regs_pkg::BIT_LOST] = ~i_locked & state_r.locked_d;
    assign o_lost_event = events[dac_regs_pkg::BIT_LOST];
    assign o_flags = state_r.flags;

    // ========================================================
    // Flag update
    // An event in the cycle of a clear still lands: set beats clear
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.locked_d = i_locked;
        for (int k = 0; k < 2; k++)
        begin
            state_nxt.flags[k] = (i_enable_cur[k] & events[k]) |
                (state_r.flags[k] & i_enable_nxt[k] & ~i_flag_clear); // RULE3
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_r <= '0;
        end
        else if (i_ce)
        begin
            state_r <= state_nxt;
        end
    end

endmodule : lock_flag_capture

/* File: dv/cfg_host_model.sv */
/* Host side of the configuration interface: byte read and write.
   Assumes one strobe a cycle is taken at the next rising edge. */
`timescale 1ns/100ps
module cfg_host_model
(
    // Clock and read data
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    // Register strobes
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    output logic o_rd
);
    initial
    begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
    end
    // Released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
        // Let the write settle so callers see the updated outputs
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask : rd
endmodule : cfg_host_model

/* File: dv/dac_control_status_regs_properties.sv */
/* Port checker for the register bank.
   Assumes binding to dac_control_status_regs. */
`timescale 1ns/100ps
module dac_regs_checker
(
    // Bank ports
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_rx_locked,
    input wire logic i_early_phase0_compare,
    input wire logic i_late_phase0_compare,
    input wire dac_regs_pkg::dac_cfg_t o_dac_cfg,
    input wire dac_regs_pkg::rx_ctrl_t o_rx_ctrl
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire logic w6 = i_ce && i_wr && i_addr == 8'h06;
    wire logic w7 = i_ce && i_wr && i_addr == 8'h07;
    wire logic w8 = i_ce && i_wr && i_addr == 8'h08;
    wire logic w10 = i_ce && i_wr && i_addr == 8'h10;
    wire logic rc = i_ce && i_rd && i_addr == 8'h0c;
    wire logic rs = i_ce && i_rd && i_addr == 8'h04;
    // ========================================================
    // Assertions
    a_fsc_low_write:
        assert property (w6 |=> o_dac_cfg.full_scale_code[7:0]
            == $past(i_wdata)) else $error("low code not stored");
    a_fsc_high_write:
        assert property (w7 |=> o_dac_cfg.full_scale_code[9:8]
            == $past(i_wdata[1:0]) && o_dac_cfg.sleep == $past(i_wdata[7]))
            else $error("high code or sleep wrong");
    a_mode_write:
        assert property (w8 |=> o_dac_cfg.switch_mode_field
            == $past(i_wdata[1:0])) else $error("mode not stored");
    a_ctrl_write:
        assert property (w10 |=> o_rx_ctrl.receiver_controller_on
            == $past(i_wdata[0]) && o_rx_ctrl.receiver_auto_relock
            == $past(i_wdata[1])) else $error("control not stored");
    a_phase_read:
        assert property (rc |=> o_rdata == {5'h00,
            $past(i_early_phase0_compare), 1'b0,
            $past(i_late_phase0_compare)}) else $error("phase bits wrong");
    a_status_reserved:
        assert property (rs |=> o_rdata[7:2] == 6'h00)
            else $error("status upper bits set");
    a_reset_values:
        assert property ($fell(i_srst) |-> o_dac_cfg == 13'h1000
            && o_rx_ctrl[3:2] == 2'b01) else $error("bad reset value");
    a_restart_pulse:
        assert property (i_ce && $fell(i_rx_locked)
            && o_rx_ctrl.receiver_auto_relock
            && o_rx_ctrl.receiver_controller_on
            |=> o_rx_ctrl.restart_search ##1 !o_rx_ctrl.restart_search)
            else $error("restart pulse wrong");
    a_flag_clear_cause:
        assert property (o_rx_ctrl.receiver_flag_clear |->
            $past(w10 && !i_wdata[2])) else $error("stray flag clear");
    c_fsc: cover property (w7);
    c_restart: cover property (o_rx_ctrl.restart_search);
    c_clear: cover property (o_rx_ctrl.receiver_flag_clear);
endmodule : dac_regs_checker

bind dac_control_status_regs dac_regs_checker u_chk (.i_clk(i_clk),
    .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wr(i_wr),
    .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rx_locked(i_rx_locked),
    .i_early_phase0_compare(i_early_phase0_compare),
    .i_late_phase0_compare(i_late_phase0_compare),
    .o_dac_cfg(o_dac_cfg), .o_rx_ctrl(o_rx_ctrl));

/* File: dv/dac_control_status_regs_tb_top.sv */
/* Self-checking bench for the register bank.
   Assumes the host model and checker compiled before it. */
`timescale 1ns/100ps
module dac_control_status_regs_tb_top;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic ce = 1'b1;
    logic lk = 1'b0;
    logic ep = 1'b0;
    logic lp = 1'b0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd;
    dac_regs_pkg::dac_cfg_t cfg;
    dac_regs_pkg::rx_ctrl_t ctl;
    int n_errors = 0;
    int samples_checked = 0;
    int restarts = 0;
    int clears = 0;
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) if (ctl.restart_search === 1'b1) restarts++;
    always @(posedge i_clk) if (ctl.receiver_flag_clear === 1'b1) clears++;
    cfg_host_model u_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
        .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
    dac_control_status_regs u_dut (.i_clk(i_clk), .i_srst(i_srst),
        .i_ce(ce), .i_addr(addr), .i_wr(wr), .i_wdata(wdata),
        .i_rd(rd), .o_rdata(rdata), .i_rx_locked(lk),
        .i_early_phase0_compare(ep), .i_late_phase0_compare(lp),
        .o_dac_cfg(cfg), .o_rx_ctrl(ctl));
    // ========================================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rchk
    task automatic lock(input logic v);
        @(posedge i_clk);
        lk <= v;
        repeat (2) @(posedge i_clk);
    endtask : lock
    task automatic results();
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // ========================================================
    // Scenarios
    task automatic t_reset();
        rchk(8'h06, 8'h00);
        rchk(8'h07, 8'h02);
        rchk(8'h08, 8'h00);
        rchk(8'h10, 8'h02);
        chk({3'h0, cfg}, 16'h1000);
    endtask : t_reset
    task automatic t_fsc();
        u_host.wr(8'h06, 8'hff);
        u_host.wr(8'h07, 8'h83);
        chk({3'h0, cfg}, {3'h0, 10'h3ff, 1'b1, 2'h0});
        rchk(8'h07, 8'h83);
        u_host.wr(8'h07, 8'h00);
        rchk(8'h06, 8'hff);
        chk({3'h0, cfg}, {3'h0, 10'h0ff, 1'b0, 2'h0});
    endtask : t_fsc
    task automatic t_mode();
        logic [7:0] m;
        for (int i = 0; i < 2; i++)
        begin
            m = i ? 8'h00 : 8'h02;
            u_host.wr(8'h08, m);
            chk({14'h0, cfg.switch_mode_field}, {8'h0, m});
            rchk(8'h08, m);
        end
    endtask : t_mode
    task automatic t_phase();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge i_clk);
            ep <= i[1];
            lp <= i[0];
            rchk(8'h0c, {5'h00, i[1], 1'b0, i[0]});
        end
    endtask : t_phase
    task automatic t_lock();
        u_host.wr(8'h10, 8'h03);
        rchk(8'h10, 8'h03);
        chk({12'h000, ctl}, 16'h000c);
        u_host.wr(8'h03, 8'h03);
        lock(1'b1);
        rchk(8'h04, 8'h01);
        lock(1'b0);
        rchk(8'h04, 8'h03);
        chk(16'(restarts), 16'h0001);
        u_host.wr(8'h03, 8'h00);
        rchk(8'h04, 8'h00);
        u_host.wr(8'h03, 8'h03);
        lock(1'b1);
        rchk(8'h04, 8'h01);
        u_host.wr(8'h10, 8'h07);
        u_host.wr(8'h10, 8'h03);
        rchk(8'h04, 8'h00);
        chk(16'(clears), 16'h0001);
        rchk(8'h20, 8'h00);
    endtask : t_lock
    // Write while the clock enable is low must be dropped
    task automatic t_ce();
        @(posedge i_clk);
        ce <= 1'b0;
        u_host.wr(8'h08, 8'h02);
        @(posedge i_clk);
        ce <= 1'b1;
        chk({3'h0, cfg}, {3'h0, 10'h0ff, 1'b0, 2'h0});
        rchk(8'h08, 8'h00);
    endtask : t_ce
    // Reset in mid-run after every register has been changed
    task automatic t_midreset();
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        t_reset();
        rchk(8'h04, 8'h00);
    endtask : t_midreset
    // ========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_srst <= 1'b0;
        t_reset();
        t_fsc();
        t_mode();
        t_ce();
        t_phase();
        t_lock();
        t_midreset();
        results();
    end
    // Whole run is about a hundred cycles; this allows far more
    initial
    begin
        #2000000;
        n_errors++;
        results();
    end
endmodule : dac_control_status_regs_tb_top
